// ### design/gpa_pkg.sv
// Package: register map, field layout and reset values of the port block
`default_nettype none
package gpa_pkg;
  localparam int unsigned gpa_aw = 5;
  localparam logic [gpa_aw-1:0] gpa_off_ans_a = 5'h00;
  localparam logic [gpa_aw-1:0] gpa_off_alt = 5'h04;
  localparam logic [gpa_aw-1:0] gpa_off_dat_a = 5'h08;
  localparam logic [gpa_aw-1:0] gpa_off_dir_a = 5'h0c;
  localparam logic [gpa_aw-1:0] gpa_off_dat_b = 5'h10;
  localparam logic [gpa_aw-1:0] gpa_off_dir_b = 5'h14;
  localparam logic [7:0] gpa_ans_mask = 8'h3f;
  localparam logic [7:0] gpa_ans_rst = 8'h3f;
  localparam logic [7:0] gpa_alt_mask = 8'h03;
  localparam logic [7:0] gpa_alt_rst = 8'h00;
  localparam logic [7:0] gpa_dir_rst = 8'hff;
  localparam logic [7:0] gpa_lat_rst = 8'h00;
  localparam int unsigned gpa_ss_bit = 1;
  localparam int unsigned gpa_t0_pin = 4;
  localparam int unsigned gpa_ss_pin_lo = 5;
  localparam int unsigned gpa_ss_pin_hi = 0;
  localparam logic [1:0] gpa_resp_okay = 2'b00;
  localparam logic [1:0] gpa_resp_slverr = 2'b10;
  typedef enum logic [1:0] {
    gpa_w_idle = 2'b00,
    gpa_w_resp = 2'b01
  } gpa_wst_e;
endpackage
`default_nettype wire

// ### design/gpa_sync.sv
// Two-stage synchroniser bank for pin inputs
`default_nettype none
module gpa_sync #(
  parameter int unsigned width = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] s1_q;
  logic [width-1:0] s2_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
    end
  end
  assign sync_out = s2_q;
endmodule
`default_nettype wire

// ### design/gpa_port.sv
// Two 8-bit ports with analog select, pin routing and AXI4-Lite registers
//
// Contract
// - Analog-selected pin always reads zero through the port data register.
// - Analog select never changes output latch or driver behaviour.
// - Analog select bits 7:6 read zero; bits 5:0 map to pins.
// - Select 0 is digital; 1 is analog: the data register reads zero, but the timer0 and slave-select taps still see the pin.
// - Timer0 clock from pin 4 works whatever its direction bit.
// - Slave-select input routes from pin 5 or pin 0.
// - Route bit 1 of alternate register: 0 pin 5, 1 pin 0.
// - Second port is 8-bit bidirectional with 8-bit direction register.
// - Direction 1 tri-states the driver; 0 drives the output latch.
// - Data read returns sampled pins; write updates output latch.
// - Port writes replace the whole latch with the written byte.
// - Direction controls driver even for analog pins.
// - First port direction 1 is input, 0 is output.
`default_nettype none
module gpa_port
  import gpa_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [gpa_pkg::gpa_aw-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpa_pkg::gpa_aw-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [5:0] analog_en,
  output logic timer0_external_clock_in,
  output logic slave_select_in
);
  import gpa_pkg::*;

  function automatic logic [7:0] pin_read(input logic [7:0] pins,
                                          input logic [7:0] ans);
    pin_read = pins & ~ans;
  endfunction

  logic [7:0] pa_sync;
  logic [7:0] pb_sync;
  gpa_sync #(.width(16)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .async_in({pb_in, pa_in}),
    .sync_out({pb_sync, pa_sync})
  );

  logic [7:0] ans_a_q, ans_a_d;
  logic [7:0] alt_q, alt_d;
  logic [7:0] lat_a_q, lat_a_d;
  logic [7:0] dir_a_q, dir_a_d;
  logic [7:0] lat_b_q, lat_b_d;
  logic [7:0] dir_b_q, dir_b_d;
  logic [7:0] rd_a, rd_b;

  assign rd_a = pin_read(pa_sync, ans_a_q);
  assign rd_b = pb_sync;

  // Write channel state
  gpa_wst_e wst_q, wst_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [gpa_aw-1:0] awaddr_q, awaddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstb_q, wstb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;

  // Read channel state
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  logic do_wr;
  logic wr_hit;

  function automatic logic addr_ok(input logic [gpa_aw-1:0] a);
    case (a)
      gpa_off_ans_a, gpa_off_alt, gpa_off_dat_a,
      gpa_off_dir_a, gpa_off_dat_b, gpa_off_dir_b: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstb_d = wstb_q;
    wst_d = wst_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_wr = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata[7:0];
      wstb_d = s_axi_wstrb[0];
    end
    case (wst_q)
      gpa_w_idle: begin
        if (aw_have_q && w_have_q) begin
          do_wr = wstb_q;
          bvalid_d = 1'b1;
          bresp_d = addr_ok(awaddr_q) ? gpa_resp_okay : gpa_resp_slverr;
          aw_have_d = 1'b0;
          w_have_d = 1'b0;
          wst_d = gpa_w_resp;
        end
      end
      gpa_w_resp: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wst_d = gpa_w_idle;
        end
      end
      default: wst_d = gpa_w_idle;
    endcase
    awready_d = !aw_have_d && (wst_d == gpa_w_idle);
    wready_d = !w_have_d && (wst_d == gpa_w_idle);
  end

  assign wr_hit = do_wr && addr_ok(awaddr_q);

  // Register writes; byte lane 0 carries all data
  always_comb begin
    ans_a_d = ans_a_q;
    alt_d = alt_q;
    lat_a_d = lat_a_q;
    dir_a_d = dir_a_q;
    lat_b_d = lat_b_q;
    dir_b_d = dir_b_q;
    if (wr_hit) begin
      case (awaddr_q)
        gpa_off_ans_a: ans_a_d = wdata_q & gpa_ans_mask;
        gpa_off_alt: alt_d = wdata_q & gpa_alt_mask;
        // Whole latch rewritten with the new byte; the pins are not read
        gpa_off_dat_a: lat_a_d = wdata_q;
        gpa_off_dir_a: dir_a_d = wdata_q;
        gpa_off_dat_b: lat_b_d = wdata_q;
        gpa_off_dir_b: dir_b_d = wdata_q;
        default: ;
      endcase
    end
  end

  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = addr_ok(s_axi_araddr) ? gpa_resp_okay : gpa_resp_slverr;
      case (s_axi_araddr)
        gpa_off_ans_a: rdata_d = {24'h000000, ans_a_q};
        gpa_off_alt: rdata_d = {24'h000000, alt_q};
        gpa_off_dat_a: rdata_d = {24'h000000, rd_a};
        gpa_off_dir_a: rdata_d = {24'h000000, dir_a_q};
        gpa_off_dat_b: rdata_d = {24'h000000, rd_b};
        gpa_off_dir_b: rdata_d = {24'h000000, dir_b_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wst_q <= gpa_w_idle;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstb_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= gpa_resp_okay;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= gpa_resp_okay;
      ans_a_q <= gpa_ans_rst;
      alt_q <= gpa_alt_rst;
      lat_a_q <= gpa_lat_rst;
      dir_a_q <= gpa_dir_rst;
      lat_b_q <= gpa_lat_rst;
      dir_b_q <= gpa_dir_rst;
    end else begin
      wst_q <= wst_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstb_q <= wstb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ans_a_q <= ans_a_d;
      alt_q <= alt_d;
      lat_a_q <= lat_a_d;
      dir_a_q <= dir_a_d;
      lat_b_q <= lat_b_d;
      dir_b_q <= dir_b_d;
    end
  end

  // Pad drive and peripheral taps, all registered
  logic [7:0] pa_out_q, pa_oe_q, pb_out_q, pb_oe_q;
  logic [5:0] an_q;
  logic t0_q, ss_q;
  logic t0_d, ss_d;

  always_comb begin
    // Pin 4 pad value feeds the timer even when driven by the latch
    t0_d = pa_sync[gpa_t0_pin];
    ss_d = alt_q[gpa_ss_bit] ? pa_sync[gpa_ss_pin_hi]
                             : pa_sync[gpa_ss_pin_lo];
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pa_out_q <= gpa_lat_rst;
      pa_oe_q <= 8'h00;
      pb_out_q <= gpa_lat_rst;
      pb_oe_q <= 8'h00;
      an_q <= gpa_ans_rst[5:0];
      t0_q <= 1'b0;
      ss_q <= 1'b0;
    end else begin
      pa_out_q <= lat_a_q;
      pa_oe_q <= ~dir_a_q;
      pb_out_q <= lat_b_q;
      pb_oe_q <= ~dir_b_q;
      an_q <= ans_a_q[5:0];
      t0_q <= t0_d;
      ss_q <= ss_d;
    end
  end

  assign pa_out = pa_out_q;
  assign pa_oe = pa_oe_q;
  assign pb_out = pb_out_q;
  assign pb_oe = pb_oe_q;
  assign analog_en = an_q;
  assign timer0_external_clock_in = t0_q;
  assign slave_select_in = ss_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Checks
  sequence s_dat_a_read;
    s_axi_arvalid && arready_q && s_axi_araddr == gpa_off_dat_a;
  endsequence
  sequence s_lat_a_write;
    wr_hit && awaddr_q == gpa_off_dat_a;
  endsequence
  sequence s_latch_to_pad;
    lat_a_q == $past(wdata_q) ##1 pa_out == $past(lat_a_q);
  endsequence
  sequence s_wr_taken;
    aw_have_q && w_have_q && wst_q == gpa_w_idle;
  endsequence
  sequence s_wr_answer;
    ##1 s_axi_bvalid;
  endsequence

  a_ans_reads_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_dat_a_read |=> ((rdata_q[7:0] & $past(ans_a_q)) == 8'h00))
    else $error("analog pin read nonzero");
  a_ans_upper_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    ans_a_q[7:6] == 2'b00)
    else $error("analog select upper bits set");
  a_ans_read_upper: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_arvalid && arready_q && s_axi_araddr == gpa_off_ans_a
    |=> rdata_q[7:6] == 2'b00)
    else $error("analog select read upper bits set");
  a_drive_follows_dir: assert property (
    @(posedge mclk) disable iff (!nrst)
    $changed(dir_a_q) |=> pa_oe == ~$past(dir_a_q))
    else $error("first port enable wrong");
  a_out_ignores_ans: assert property (
    @(posedge mclk) disable iff (!nrst)
    $stable(lat_a_q) && $changed(ans_a_q) |=> $stable(pa_out))
    else $error("analog select moved output");
  a_pb_dir_drive: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 pb_oe == ~$past(dir_b_q) && pb_out == $past(lat_b_q))
    else $error("second port drive wrong");
  a_ss_route: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 slave_select_in == ($past(alt_q[gpa_ss_bit])
      ? $past(pa_sync[gpa_ss_pin_hi])
      : $past(pa_sync[gpa_ss_pin_lo])))
    else $error("slave select route wrong");
  a_t0_any_dir: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 timer0_external_clock_in == $past(pa_sync[gpa_t0_pin]))
    else $error("timer clock tap wrong");
  a_analog_en_copy: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 analog_en == $past(ans_a_q[5:0]))
    else $error("analog enable copy wrong");
  a_pin_sync_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_arvalid && arready_q && s_axi_araddr == gpa_off_dat_b
    |=> rdata_q[7:0] == $past(pb_in, 3))
    else $error("second port read not synchronised");
  a_latch_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_lat_a_write |=> s_latch_to_pad)
    else $error("latch write lost");
  a_wr_answer: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_wr_taken |-> s_wr_answer)
    else $error("write answer missing");
endmodule
`default_nettype wire

// ### verif/gpa_pads.sv
// Pad model: resolves on-chip drivers against external sources
`default_nettype none
module gpa_pads (
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_ext,
  output logic [7:0] pa_in,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pb_ext,
  output logic [7:0] pb_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Enabled driver wins, otherwise the outside source sets the pad
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
endmodule
`default_nettype wire

// ### verif/gpio_port_analog_select_tb.sv
// Testbench for the two-port block with analog select
`default_nettype none
module gpio_port_analog_select_tb;
  import gpa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, nrst = 0;
  logic [4:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, t0, ss;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic [7:0] pa_ext = 8'h00, pb_ext = 8'h00;
  logic [5:0] aen;
  int fails = 0, n_tests = 0, cyc = 0;
  always #50 mclk = ~mclk;
  gpa_port u_dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .analog_en(aen), .timer0_external_clock_in(t0),
    .slave_select_in(ss));
  gpa_pads u_pads (.pa_out(pa_out), .pa_oe(pa_oe), .pa_ext(pa_ext),
    .pa_in(pa_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_ext(pb_ext),
    .pb_in(pb_in));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic [1:0] er = gpa_resp_okay);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e,
                    input logic [1:0] er = gpa_resp_okay);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic t_reset;
    chk("analog_en", 32'h3f, {26'h0, aen});
    chk("pa_oe", 32'h0, {24'h0, pa_oe});
    chk("pb_oe", 32'h0, {24'h0, pb_oe});
    rd(gpa_off_ans_a, 8'h3f);
    rd(gpa_off_alt, 8'h00);
    rd(gpa_off_dir_a, 8'hff);
    rd(gpa_off_dir_b, 8'hff);
  endtask
  task automatic t_analog;
    pa_ext <= 8'hff;
    wt(4);
    rd(gpa_off_dat_a, 8'hc0);
    wr(gpa_off_ans_a, 8'hff);
    rd(gpa_off_ans_a, 8'h3f);
    wr(gpa_off_ans_a, 8'h00);
    wt(4);
    chk("analog_en", 32'h0, {26'h0, aen});
    rd(gpa_off_dat_a, 8'hff);
  endtask
  task automatic t_drive;
    wr(gpa_off_ans_a, 8'h3f);
    wr(gpa_off_dat_a, 8'h5a);
    wr(gpa_off_dir_a, 8'h00);
    pa_ext <= 8'ha5;
    wt(4);
    chk("pa_out", 32'h5a, {24'h0, pa_out});
    chk("pa_oe", 32'hff, {24'h0, pa_oe});
    rd(gpa_off_dat_a, 8'h40);
    // All first-port pins go back to input
    wr(gpa_off_dir_a, 8'hff);
    wt(3);
    chk("pa_oe", 32'h0, {24'h0, pa_oe});
  endtask
  task automatic t_timer;
    wr(gpa_off_ans_a, 8'h00);
    wr(gpa_off_dir_a, 8'hef);
    pa_ext <= 8'hff;
    wr(gpa_off_dat_a, 8'h00);
    wt(5);
    chk("timer0", 32'h0, {31'h0, t0});
    wr(gpa_off_dat_a, 8'h10);
    wt(5);
    chk("timer0", 32'h1, {31'h0, t0});
    wr(gpa_off_dir_a, 8'hff);
  endtask
  task automatic t_ss;
    pa_ext <= 8'h20;
    wr(gpa_off_alt, 8'h00);
    wt(5);
    chk("ss", 32'h1, {31'h0, ss});
    wr(gpa_off_alt, 8'h02);
    wt(5);
    chk("ss", 32'h0, {31'h0, ss});
    pa_ext <= 8'h01;
    wt(5);
    chk("ss", 32'h1, {31'h0, ss});
    rd(gpa_off_alt, 8'h02);
  endtask
  task automatic t_second_port_data;
    pb_ext <= 8'h3c;
    wr(gpa_off_dir_b, 8'h0f);
    wr(gpa_off_dat_b, 8'ha5);
    wt(4);
    chk("pb_oe", 32'hf0, {24'h0, pb_oe});
    chk("pb_out", 32'ha5, {24'h0, pb_out});
    rd(gpa_off_dat_b, 8'hac);
    rd(gpa_off_dir_b, 8'h0f);
  endtask
  task automatic t_unmapped;
    wr(5'h18, 8'h55, gpa_resp_slverr);
    rd(5'h18, 8'h00, gpa_resp_slverr);
    // Lane 0 strobe low: answer OKAY, register kept
    wstrb <= 4'h0;
    wr(gpa_off_ans_a, 8'h3f);
    wstrb <= 4'hf;
    rd(gpa_off_ans_a, 8'h00);
  endtask
  initial begin
    wt(10);
    nrst <= 1;
    wt(1);
    t_reset();
    t_analog();
    t_drive();
    t_timer();
    t_ss();
    t_second_port_data();
    t_unmapped();
    wt(2);
    test_done();
  end
endmodule
`default_nettype wire
